// ===== common/imo_pkg.sv
// Register map, field positions and reset values of the mode/output bank
package imo_pkg;

  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [6:0] OFF_PORT_POWER_CONTROL = 7'h02;
  localparam logic [6:0] OFF_ACCEL_CONFIG       = 7'h03;
  localparam logic [6:0] OFF_GYRO_CONFIG        = 7'h04;
  localparam logic [6:0] OFF_MAGNET_CONFIG      = 7'h05;
  localparam logic [6:0] OFF_FILTER_CONFIG      = 7'h06;
  localparam logic [6:0] OFF_ENGINE_CONFIG      = 7'h07;
  localparam logic [6:0] OFF_SENSOR_ENABLES     = 7'h08;
  localparam logic [6:0] OFF_STATUS_FIRST       = 7'h16;
  localparam logic [6:0] OFF_STATUS_SECOND      = 7'h17;
  localparam logic [6:0] OFF_SAMPLE_STAMP       = 7'h18;
  localparam logic [6:0] OFF_ACCEL_BASE         = 7'h19;
  localparam logic [6:0] OFF_GYRO_BASE          = 7'h1F;
  localparam logic [6:0] OFF_MAGNET_BASE        = 7'h25;
  localparam logic [6:0] OFF_QUAT_BASE          = 7'h2D;
  localparam logic [6:0] OFF_VEL_BASE           = 7'h35;
  localparam logic [6:0] OFF_TEMPERATURE_OUT    = 7'h3B;
  localparam logic [6:0] OFF_ENGINE_FLAGS_FIRST = 7'h3C;
  localparam logic [6:0] OFF_ENGINE_FLAGS_SECOND = 7'h3D;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int BIT_ACCEL_ON      = 0;
  localparam int BIT_GYRO_ON       = 1;
  localparam int BIT_MAGNET_ON     = 2;
  localparam int BIT_ENGINE_SELECT = 3;
  localparam int BIT_SAMPLE_LOCK   = 7;
  localparam int BIT_DATA_ACCEL    = 0;
  localparam int BIT_DATA_GYRO     = 1;
  localparam int BIT_DATA_MAGNET   = 2;
  localparam int BIT_OVR_ACCEL     = 4;
  localparam int BIT_OVR_GYRO      = 5;
  localparam int BIT_OVR_MAGNET    = 6;
  localparam int BIT_WAKE_MOTION   = 0;
  localparam int BIT_CMD_DONE      = 1;
  localparam int BIT_FIFO_READY    = 2;
  localparam int BIT_ENGINE_DATA   = 3;
  localparam int BIT_MAG_BIAS_ACK  = 0;
  localparam int BIT_GYR_BIAS_ACK  = 1;
  localparam int BIT_CLIP_ACK      = 2;
  localparam int BIT_VEL_OVERFLOW  = 0;

  // ************************************************************
  // Reset values and the sample stamp wrap point
  // ************************************************************
  localparam logic [7:0] RST_REG  = 8'h00;
  localparam logic [7:0] RST_TEMP = 8'h00;
  localparam logic [7:0] STAMP_WRAP = 8'hFF;

endpackage

// ===== verilog/imo_mode_output_regs.sv
// Mode selection and output register bank of the inertial unit
`timescale 1ns/100ps
`default_nettype none
module imo_mode_output_regs (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  input  wire logic [6:0]  regAddr,
  input  wire logic [7:0]  regWdata,
  output logic      [7:0]  regRdata,
  output logic             engineSelect,
  output logic             accelOn,
  output logic             gyroOn,
  output logic             magnetOn,
  output logic      [7:0]  accelConfig,
  output logic      [7:0]  gyroConfig,
  output logic      [7:0]  magnetConfig,
  output logic      [7:0]  filterConfig,
  output logic      [7:0]  engineConfig,
  output logic      [7:0]  portPowerControl,
  input  wire logic        sampleTick,
  input  wire logic [47:0] rawAccel,
  input  wire logic [47:0] rawGyro,
  input  wire logic [47:0] rawMagnet,
  input  wire logic [7:0]  rawTemp,
  input  wire logic        engineTick,
  input  wire logic [63:0] engQuat,
  input  wire logic [47:0] engVel,
  input  wire logic [47:0] engMagnet,
  input  wire logic [7:0]  engFlagsFirst,
  input  wire logic [7:0]  engFlagsSecond,
  input  wire logic        wakeMotion,
  input  wire logic        fifoReady,
  input  wire logic        cmdDone
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [7:0]   rdata;
    logic [7:0]   ctlPower;
    logic [7:0]   ctlAccel;
    logic [7:0]   ctlGyro;
    logic [7:0]   ctlMagnet;
    logic [7:0]   ctlFilter;
    logic [7:0]   ctlEngine;
    logic [7:0]   ctlEnables;
    logic [7:0]   stat0;
    logic [7:0]   stat1;
    logic [7:0]   stamp;
    logic [47:0]  accel;
    logic [47:0]  gyro;
    logic [47:0]  magnet;
    logic [63:0]  quat;
    logic [47:0]  vel;
    logic [7:0]   temp;
    logic [7:0]   flags1;
    logic [7:0]   flags2;
    logic [7:0]   heldHigh;
  } imo_state_t;

  imo_state_t st_r;
  imo_state_t st_nxt;

  // Picks byte n of a packed vector of 16-bit words, low byte first
  function automatic logic [7:0] pickByte(input logic [63:0] v,
                                          input logic [2:0]  n);
    pickByte = v[{n, 3'h0} +: 8];
  endfunction

  function automatic logic inRange(input logic [6:0] a,
                                   input logic [6:0] base,
                                   input logic [6:0] len);
    inRange = (a >= base) && (a < 7'(base + len));
  endfunction

  logic       engMode;
  logic       lockOn;
  logic [6:0] rdIdx;
  logic [7:0] rdByte;
  logic [2:0] rdSel;
  logic       freshSample;

  always_comb begin
    engMode = st_r.ctlEnables[imo_pkg::BIT_ENGINE_SELECT];
    lockOn  = st_r.ctlEnables[imo_pkg::BIT_SAMPLE_LOCK];
    rdIdx   = 7'h00;
    rdSel   = 3'h0;
    rdByte  = imo_pkg::RST_REG;
    st_nxt  = st_r;

    // ************************************************************
    // Control register writes
    // ************************************************************
    if (regWrite) begin
      unique case (regAddr)
        imo_pkg::OFF_PORT_POWER_CONTROL: st_nxt.ctlPower = regWdata;
        imo_pkg::OFF_ACCEL_CONFIG: st_nxt.ctlAccel = regWdata;
        imo_pkg::OFF_GYRO_CONFIG: st_nxt.ctlGyro = regWdata;
        imo_pkg::OFF_MAGNET_CONFIG: st_nxt.ctlMagnet = regWdata;
        imo_pkg::OFF_FILTER_CONFIG: st_nxt.ctlFilter = regWdata;
        imo_pkg::OFF_ENGINE_CONFIG: st_nxt.ctlEngine = regWdata;
        imo_pkg::OFF_SENSOR_ENABLES: st_nxt.ctlEnables = regWdata;
        default: ;
      endcase
    end

    // ************************************************************
    // Sample capture
    // ************************************************************
    // Read-clear first, so a sample taken in the same cycle sets again
    if (regRead && regAddr == imo_pkg::OFF_STATUS_FIRST) begin
      st_nxt.stat0 = imo_pkg::RST_REG;
    end

    // With sample lock on, new sensor and engine data (not stamp or temperature) are held off while a multi-byte
    // read is in progress (high byte still pending) to keep words whole
    freshSample = !(lockOn && (st_r.heldHigh != 8'h00));

    if (sampleTick) begin
      st_nxt.stamp = (st_r.stamp == imo_pkg::STAMP_WRAP) ? 8'h00
                     : 8'(st_r.stamp + 8'h01);
      st_nxt.temp = rawTemp;
      if (!engMode && freshSample) begin
        if (st_r.ctlEnables[imo_pkg::BIT_ACCEL_ON]) begin
          st_nxt.accel = rawAccel;
          st_nxt.stat0[imo_pkg::BIT_OVR_ACCEL] =
            st_nxt.stat0[imo_pkg::BIT_DATA_ACCEL];
          st_nxt.stat0[imo_pkg::BIT_DATA_ACCEL] = 1'b1;
        end
        if (st_r.ctlEnables[imo_pkg::BIT_GYRO_ON]) begin
          st_nxt.gyro = rawGyro;
          st_nxt.stat0[imo_pkg::BIT_OVR_GYRO] =
            st_nxt.stat0[imo_pkg::BIT_DATA_GYRO];
          st_nxt.stat0[imo_pkg::BIT_DATA_GYRO] = 1'b1;
        end
        if (st_r.ctlEnables[imo_pkg::BIT_MAGNET_ON]) begin
          st_nxt.magnet = rawMagnet;
          st_nxt.stat0[imo_pkg::BIT_OVR_MAGNET] =
            st_nxt.stat0[imo_pkg::BIT_DATA_MAGNET];
          st_nxt.stat0[imo_pkg::BIT_DATA_MAGNET] = 1'b1;
        end
      end
    end

    if (engineTick && engMode && freshSample) begin
      st_nxt.quat = engQuat;
      st_nxt.vel  = engVel;
      if (st_r.ctlEnables[imo_pkg::BIT_MAGNET_ON]) begin
        st_nxt.magnet = engMagnet;
      end
      st_nxt.flags1 = engFlagsFirst;
      st_nxt.flags2 = engFlagsSecond;
      st_nxt.stat1[imo_pkg::BIT_ENGINE_DATA] = 1'b1;
    end

    // ************************************************************
    // Status levels from the rest of the unit
    // ************************************************************
    st_nxt.stat1[imo_pkg::BIT_WAKE_MOTION] = engMode && wakeMotion;
    st_nxt.stat1[imo_pkg::BIT_FIFO_READY]  = fifoReady;
    st_nxt.stat1[imo_pkg::BIT_CMD_DONE]    = cmdDone;

    // ************************************************************
    // Read decode
    // ************************************************************
    if (inRange(regAddr, imo_pkg::OFF_ACCEL_BASE, 7'h06)) begin
      rdIdx  = 7'(regAddr - imo_pkg::OFF_ACCEL_BASE);
      rdSel  = rdIdx[2:0];
      rdByte = pickByte({16'h0000, st_r.accel}, rdSel);
    end else if (inRange(regAddr, imo_pkg::OFF_GYRO_BASE, 7'h06)) begin
      rdIdx  = 7'(regAddr - imo_pkg::OFF_GYRO_BASE);
      rdSel  = rdIdx[2:0];
      rdByte = pickByte({16'h0000, st_r.gyro}, rdSel);
    end else if (inRange(regAddr, imo_pkg::OFF_MAGNET_BASE, 7'h06)) begin
      rdIdx  = 7'(regAddr - imo_pkg::OFF_MAGNET_BASE);
      rdSel  = rdIdx[2:0];
      rdByte = pickByte({16'h0000, st_r.magnet}, rdSel);
    end else if (inRange(regAddr, imo_pkg::OFF_QUAT_BASE, 7'h08)) begin
      rdIdx  = 7'(regAddr - imo_pkg::OFF_QUAT_BASE);
      rdSel  = rdIdx[2:0];
      rdByte = pickByte(st_r.quat, rdSel);
    end else if (inRange(regAddr, imo_pkg::OFF_VEL_BASE, 7'h06)) begin
      rdIdx  = 7'(regAddr - imo_pkg::OFF_VEL_BASE);
      rdSel  = rdIdx[2:0];
      rdByte = pickByte({16'h0000, st_r.vel}, rdSel);
    end else begin
      unique case (regAddr)
        imo_pkg::OFF_PORT_POWER_CONTROL:  rdByte = st_r.ctlPower;
        imo_pkg::OFF_ACCEL_CONFIG:        rdByte = st_r.ctlAccel;
        imo_pkg::OFF_GYRO_CONFIG:         rdByte = st_r.ctlGyro;
        imo_pkg::OFF_MAGNET_CONFIG:       rdByte = st_r.ctlMagnet;
        imo_pkg::OFF_FILTER_CONFIG:       rdByte = st_r.ctlFilter;
        imo_pkg::OFF_ENGINE_CONFIG:       rdByte = st_r.ctlEngine;
        imo_pkg::OFF_SENSOR_ENABLES:      rdByte = st_r.ctlEnables;
        imo_pkg::OFF_STATUS_FIRST:        rdByte = st_r.stat0;
        imo_pkg::OFF_STATUS_SECOND:       rdByte = st_r.stat1;
        imo_pkg::OFF_SAMPLE_STAMP:        rdByte = st_r.stamp;
        imo_pkg::OFF_TEMPERATURE_OUT:     rdByte = st_r.temp;
        imo_pkg::OFF_ENGINE_FLAGS_FIRST:  rdByte = st_r.flags1;
        imo_pkg::OFF_ENGINE_FLAGS_SECOND: rdByte = st_r.flags2;
        default:                          rdByte = imo_pkg::RST_REG;
      endcase
    end

    // ************************************************************
    // Read side effects
    // ************************************************************
    if (regRead) begin
      st_nxt.rdata = rdByte;
      // Reading status second clears its engine-data bit, except in a cycle with engineTick high
      if (regAddr == imo_pkg::OFF_STATUS_SECOND && !engineTick) begin
        st_nxt.stat1[imo_pkg::BIT_ENGINE_DATA] = 1'b0;
      end
      // Low byte read arms the hold, high byte read releases it
      if (regAddr >= imo_pkg::OFF_ACCEL_BASE
          && regAddr < imo_pkg::OFF_TEMPERATURE_OUT) begin
        st_nxt.heldHigh = regAddr[0] ? 8'h01 : 8'h00;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign regRdata         = st_r.rdata;
  assign engineSelect     = st_r.ctlEnables[imo_pkg::BIT_ENGINE_SELECT];
  assign accelOn          = st_r.ctlEnables[imo_pkg::BIT_ACCEL_ON];
  assign gyroOn           = st_r.ctlEnables[imo_pkg::BIT_GYRO_ON];
  assign magnetOn         = st_r.ctlEnables[imo_pkg::BIT_MAGNET_ON];
  assign accelConfig      = st_r.ctlAccel;
  assign gyroConfig       = st_r.ctlGyro;
  assign magnetConfig     = st_r.ctlMagnet;
  assign filterConfig     = st_r.ctlFilter;
  assign engineConfig     = st_r.ctlEngine;
  assign portPowerControl = st_r.ctlPower;

  // ************************************************************
  // Checks
  // ************************************************************
  property p_stampWrap;
    @(posedge clock) disable iff (rst)
      sampleTick && st_r.stamp == 8'hFF |=> st_r.stamp == 8'h00;
  endproperty
  a_stampWrap: assert property (p_stampWrap)
    else $error("stamp no wrap");

  property p_stampStep;
    @(posedge clock) disable iff (rst)
      sampleTick && st_r.stamp != 8'hFF
        |=> st_r.stamp == 8'($past(st_r.stamp) + 8'h01);
  endproperty
  a_stampStep: assert property (p_stampStep)
    else $error("stamp step");

  property p_rawHoldInEngine;
    @(posedge clock) disable iff (rst)
      engineSelect |=> $stable(st_r.accel);
  endproperty
  a_rawHoldInEngine: assert property (p_rawHoldInEngine)
    else $error("raw moved");

  property p_accelOff;
    @(posedge clock) disable iff (rst)
      !accelOn |=> $stable(st_r.accel);
  endproperty
  a_accelOff: assert property (p_accelOff)
    else $error("accel off moved");

  property p_quatLoad;
    @(posedge clock) disable iff (rst)
      engineTick && engineSelect
        && (!lockOn || st_r.heldHigh == 8'h00)
        |=> st_r.quat == $past(engQuat);
  endproperty
  a_quatLoad: assert property (p_quatLoad)
    else $error("quat not loaded");

  property p_tempRead;
    @(posedge clock) disable iff (rst)
      regRead && regAddr == imo_pkg::OFF_TEMPERATURE_OUT
        |=> regRdata == $past(st_r.temp);
  endproperty
  a_tempRead: assert property (p_tempRead)
    else $error("temp read");

  property p_lockHold;
    @(posedge clock) disable iff (rst)
      lockOn && st_r.heldHigh != 8'h00 |=> $stable(st_r.vel);
  endproperty
  a_lockHold: assert property (p_lockHold)
    else $error("lock broken");

  property p_ctlWrite;
    @(posedge clock) disable iff (rst)
      regWrite && regAddr == imo_pkg::OFF_FILTER_CONFIG
        |=> filterConfig == $past(regWdata);
  endproperty
  a_ctlWrite: assert property (p_ctlWrite)
    else $error("filter write");

endmodule
`default_nettype wire

// ===== verif/imo_host_model.sv
// Host processor model that drives the register port of the bank
`timescale 1ns/100ps
`default_nettype none
module imo_host_model (
  input  wire logic       clock,
  output logic            regWrite,
  output logic            regRead,
  output logic      [6:0] regAddr,
  output logic      [7:0] regWdata,
  input  wire logic [7:0] regRdata
);
  // Strobes idle low so nothing is taken while reset is applied
  initial begin
    regWrite = 1'b0;
    regRead  = 1'b0;
    regAddr  = 7'h00;
    regWdata = 8'h00;
  end

  // Released address and data show the inverse, never a stale copy
  task automatic writeReg(input logic [6:0] a, input logic [7:0] d);
    @(negedge clock);
    regWrite = 1'b1;
    regAddr  = a;
    regWdata = d;
    @(negedge clock);
    regWrite = 1'b0;
    regAddr  = ~a;
    regWdata = ~d;
  endtask

  // Data is taken once the edge that accepts the strobe has passed
  task automatic readReg(input logic [6:0] a, output logic [7:0] d);
    @(negedge clock);
    regRead = 1'b1;
    regAddr = a;
    @(negedge clock);
    d       = regRdata;
    regRead = 1'b0;
    regAddr = ~a;
  endtask

  task automatic startEngine(input logic magnet);
    writeReg(imo_pkg::OFF_SENSOR_ENABLES, {5'h01, magnet, 2'b11});
  endtask
endmodule
`default_nettype wire

// ===== verif/imo_mode_output_regs_tb.sv
// Self-checking bench for the mode and output register bank
`timescale 1ns/100ps
`default_nettype none
module imo_mode_output_regs_tb;
  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] data;
    logic [7:0] outExp;
  } imo_row_t;
  localparam int CYC_LIMIT = 5000;
  logic        clock, rst, regWrite, regRead, sampleTick, engineTick;
  logic [6:0]  regAddr;
  logic [7:0]  regWdata, regRdata, rawTemp, engFlagsFirst, engFlagsSecond;
  logic        engineSelect, accelOn, gyroOn, magnetOn;
  logic [7:0]  accelConfig, gyroConfig, magnetConfig;
  logic [7:0]  filterConfig, engineConfig, portPowerControl;
  logic [47:0] rawAccel, rawGyro, rawMagnet, engVel, engMagnet;
  logic [63:0] engQuat;
  logic        wakeMotion, fifoReady, cmdDone;
  int          failures, cmpCount, cycles;
  imo_row_t    rows [8] = '{'{7'h02, 8'hA5, 8'hA5}, '{7'h03, 8'h3C, 8'h3C},
    '{7'h04, 8'h5A, 8'h5A}, '{7'h05, 8'hC3, 8'hC3}, '{7'h06, 8'h96, 8'h96},
    '{7'h07, 8'h69, 8'h69}, '{7'h08, 8'h0B, 8'h0B}, '{7'h08, 8'h87, 8'h07}};

  imo_mode_output_regs u_dut (
    .clock(clock), .rst(rst), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
    .engineSelect(engineSelect), .accelOn(accelOn), .gyroOn(gyroOn),
    .magnetOn(magnetOn), .accelConfig(accelConfig),
    .gyroConfig(gyroConfig), .magnetConfig(magnetConfig),
    .filterConfig(filterConfig), .engineConfig(engineConfig),
    .portPowerControl(portPowerControl), .sampleTick(sampleTick),
    .rawAccel(rawAccel), .rawGyro(rawGyro), .rawMagnet(rawMagnet),
    .rawTemp(rawTemp), .engineTick(engineTick), .engQuat(engQuat),
    .engVel(engVel), .engMagnet(engMagnet),
    .engFlagsFirst(engFlagsFirst), .engFlagsSecond(engFlagsSecond),
    .wakeMotion(wakeMotion), .fifoReady(fifoReady), .cmdDone(cmdDone)
  );

  imo_host_model u_host (
    .clock(clock), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata)
  );

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // ************************************************************
  // Checking helpers
  // ************************************************************
  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", cmpCount, failures);
    if (failures == 0 && cmpCount > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // A hung handshake would otherwise stall the run forever
  always @(posedge clock) begin
    cycles++;
    if (cycles == CYC_LIMIT) begin
      failures++;
      $display("ERROR %0t: cycle limit reached", $time);
      stop_test();
    end
  end

  task automatic checkByte(input logic [7:0] got, input logic [7:0] exp);
    cmpCount++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic readCheck(input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] d;
    u_host.readReg(a, d);
    checkByte(d, exp);
  endtask

  // Reads n byte registers from a and compares them with v, low byte first
  task automatic checkBytes(input logic [6:0] a, input logic [63:0] v,
                            input int n);
    for (int i = 0; i < n; i++) begin
      readCheck(a + 7'(i), v[8 * i +: 8]);
    end
  endtask

  function automatic logic [7:0] outFor(input logic [6:0] a);
    case (a)
      imo_pkg::OFF_PORT_POWER_CONTROL: return portPowerControl;
      imo_pkg::OFF_ACCEL_CONFIG:       return accelConfig;
      imo_pkg::OFF_GYRO_CONFIG:        return gyroConfig;
      imo_pkg::OFF_MAGNET_CONFIG:      return magnetConfig;
      imo_pkg::OFF_FILTER_CONFIG:      return filterConfig;
      imo_pkg::OFF_ENGINE_CONFIG:      return engineConfig;
      default: return {4'h0, engineSelect, magnetOn, gyroOn, accelOn};
    endcase
  endfunction

  task automatic pulse(input logic eng);
    @(negedge clock);
    sampleTick = !eng;
    engineTick = eng;
    @(negedge clock);
    sampleTick = 1'b0;
    engineTick = 1'b0;
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    rst = 1'b1;
    {sampleTick, engineTick, wakeMotion, fifoReady, cmdDone} = 5'h00;
    {rawAccel, rawGyro, rawMagnet, engVel, engMagnet} = '0;
    {engQuat, rawTemp, engFlagsFirst, engFlagsSecond} = '0;
    repeat (5) @(negedge clock);
    foreach (rows[i]) checkByte(outFor(rows[i].addr), 8'h00);
    rst = 1'b0;
    for (int a = 8'h3B; a <= 8'h3D; a++) readCheck(7'(a), 8'h00);
    foreach (rows[i]) begin
      u_host.writeReg(rows[i].addr, rows[i].data);
      checkByte(outFor(rows[i].addr), rows[i].outExp);
      readCheck(rows[i].addr, rows[i].data);
    end
    // Raw mode with all three sensors enabled by the last row
    rawAccel  = 48'h0605_0403_0201;
    rawGyro   = 48'h1615_1413_1211;
    rawMagnet = 48'h2625_2423_2221;
    rawTemp   = 8'h19;
    wakeMotion = 1'b1;
    cmdDone    = 1'b1;
    pulse(1'b0);
    readCheck(imo_pkg::OFF_STATUS_FIRST, 8'h07);
    readCheck(imo_pkg::OFF_STATUS_FIRST, 8'h00);
    readCheck(imo_pkg::OFF_STATUS_SECOND, 8'h02);
    checkBytes(imo_pkg::OFF_ACCEL_BASE, 64'(rawAccel), 6);
    checkBytes(imo_pkg::OFF_GYRO_BASE, 64'(rawGyro), 6);
    checkBytes(imo_pkg::OFF_MAGNET_BASE, 64'(rawMagnet), 6);
    readCheck(imo_pkg::OFF_TEMPERATURE_OUT, 8'h19);
    readCheck(imo_pkg::OFF_SAMPLE_STAMP, 8'h01);
    pulse(1'b0);
    pulse(1'b0);
    readCheck(imo_pkg::OFF_STATUS_FIRST, 8'h77);
    // Locked reads: a low byte holds the set until a high byte is read
    u_host.writeReg(imo_pkg::OFF_SENSOR_ENABLES, 8'h87);
    rawAccel = 48'h0000_0000_B1A1;
    pulse(1'b0);
    readCheck(imo_pkg::OFF_ACCEL_BASE, 8'hA1);
    rawAccel = 48'h0000_0000_B2A2;
    pulse(1'b0);
    readCheck(imo_pkg::OFF_ACCEL_BASE + 7'h01, 8'hB1);
    pulse(1'b0);
    readCheck(imo_pkg::OFF_ACCEL_BASE, 8'hA2);
    u_host.writeReg(imo_pkg::OFF_SENSOR_ENABLES, 8'h07);
    repeat (249) pulse(1'b0);
    readCheck(imo_pkg::OFF_SAMPLE_STAMP, 8'hFF);
    pulse(1'b0);
    readCheck(imo_pkg::OFF_SAMPLE_STAMP, 8'h00);
    // A read-clear and a new sample in one cycle: the new sample wins
    fork
      pulse(1'b0);
      readCheck(imo_pkg::OFF_STATUS_FIRST, 8'h77);
    join
    readCheck(imo_pkg::OFF_STATUS_FIRST, 8'h07);
    // Engine mode
    u_host.startEngine(1'b1);
    engQuat   = 64'h4847_4645_4443_4241;
    engVel    = 48'h5655_5453_5251;
    engMagnet = 48'h6665_6463_6261;
    engFlagsFirst  = 8'h05;
    engFlagsSecond = 8'h01;
    fifoReady = 1'b1;
    pulse(1'b1);
    readCheck(imo_pkg::OFF_STATUS_SECOND, 8'h0F);
    checkBytes(imo_pkg::OFF_QUAT_BASE, engQuat, 8);
    checkBytes(imo_pkg::OFF_VEL_BASE, 64'(engVel), 6);
    checkBytes(imo_pkg::OFF_MAGNET_BASE, 64'(engMagnet), 6);
    readCheck(imo_pkg::OFF_ENGINE_FLAGS_FIRST, 8'h05);
    readCheck(imo_pkg::OFF_ENGINE_FLAGS_SECOND, 8'h01);
    // Read-only and unmapped places
    u_host.writeReg(imo_pkg::OFF_TEMPERATURE_OUT, 8'h55);
    readCheck(imo_pkg::OFF_TEMPERATURE_OUT, 8'h19);
    readCheck(7'h7F, 8'h00);
    // Reset in mid-run returns the bank to its reset state
    @(negedge clock);
    rst = 1'b1;
    repeat (2) @(negedge clock);
    rst = 1'b0;
    checkByte(outFor(imo_pkg::OFF_SENSOR_ENABLES), 8'h00);
    readCheck(imo_pkg::OFF_ENGINE_CONFIG, 8'h00);
    readCheck(imo_pkg::OFF_TEMPERATURE_OUT, 8'h00);
    readCheck(imo_pkg::OFF_SAMPLE_STAMP, 8'h00);
    readCheck(imo_pkg::OFF_QUAT_BASE, 8'h00);
    readCheck(imo_pkg::OFF_STATUS_SECOND, 8'h06);
    stop_test();
  end
endmodule
`default_nettype wire
